// *** core/bmw_pkg.sv ***
`default_nettype none
package bmw_pkg;

  // ==========================================================================
  // Register offsets (byte addresses in configuration space)
  localparam logic [7:0] BMW_OFF_MEM_BASE = 8'h20;
  localparam logic [7:0] BMW_OFF_MEM_LIMIT = 8'h22;
  localparam logic [7:0] BMW_OFF_PF_BASE = 8'h24;
  localparam logic [7:0] BMW_OFF_PF_LIMIT = 8'h26;

  // ==========================================================================
  // Field layout
  localparam int BMW_BOUND_LSB = 4;
  localparam int BMW_BOUND_W = 12;
  localparam int BMW_LOW_ADDR_W = 20;
  localparam logic [3:0] BMW_WIDE_ADDRESS_FLAG = 4'h1;
  localparam logic [3:0] BMW_RSVD_LOW = 4'h0;
  localparam logic [19:0] BMW_LOW_ZERO = 20'h00000;
  localparam logic [19:0] BMW_LOW_ONES = 20'hFFFFF;

  // ==========================================================================
  // Reset values
  localparam logic [11:0] BMW_BOUND_RST = 12'h000;
  localparam logic [15:0] BMW_MEM_RST = 16'h0000;
  localparam logic [15:0] BMW_PF_RST = 16'h0001;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
    logic [1:0] be;
  } bmw_cfg_req_t;

  typedef struct packed {
    logic rvalid;
    logic [15:0] rdata;
  } bmw_cfg_rsp_t;

  typedef struct packed {
    logic mem_hit;
    logic pf_hit;
  } bmw_hit_t;

endpackage
`default_nettype wire

// *** core/bmw_regs.sv ***
`timescale 1ns/10ps
`default_nettype none

// Contract
// R01: Writable 12-bit memory window base forms address bits 31:20, low bits zero.
// R02: Writable 12-bit memory window limit forms bits 31:20, low bits all ones.
// R03: Memory base and limit low four bits read zero, writes ignored.
// R04: Writable prefetch base bits 31:20; upper 32 bits from companion input.
// R05: Writable prefetch limit bits 31:20; upper 32 bits from companion input.
// R06: Prefetch registers low four bits read fixed one, writes ignored.
// R07: Each base/limit pair decides whether a memory transaction is forwarded.
// R08: Reset: memory registers read zero, prefetch registers read 0001h.
// R09: Compare inclusive both ends; limit below base never hits; prefetch uses 64 bits.
module bmw_regs
  import bmw_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire bmw_cfg_req_t cfg_req,
  output bmw_cfg_rsp_t cfg_rsp,
  input wire logic [31:0] pf_base_upper,
  input wire logic [31:0] pf_limit_upper,
  input wire logic txn_valid,
  input wire logic [63:0] txn_addr,
  output bmw_hit_t hit
);

  // ==========================================================================
  // Bound storage
  logic [11:0] window_low_bound_ff;
  logic [11:0] window_high_bound_ff;
  logic [11:0] prefetch_low_bound_ff;
  logic [11:0] prefetch_high_bound_ff;

  // Merge a write into a bound, honouring byte enables; low nibble never stored
  function automatic logic [11:0] bmw_merge(input logic [11:0] cur, input logic [15:0] wd,
                                             input logic [1:0] be);
    logic [11:0] r;
    r = cur;
    if (be[0]) begin
      r[3:0] = wd[7:4];
    end
    if (be[1]) begin
      r[11:4] = wd[15:8];
    end
    return r;
  endfunction

  logic wr_mb;
  logic wr_ml;
  logic wr_pb;
  logic wr_pl;
  assign wr_mb = cfg_req.wr && (cfg_req.addr == BMW_OFF_MEM_BASE);
  assign wr_ml = cfg_req.wr && (cfg_req.addr == BMW_OFF_MEM_LIMIT);
  assign wr_pb = cfg_req.wr && (cfg_req.addr == BMW_OFF_PF_BASE);
  assign wr_pl = cfg_req.wr && (cfg_req.addr == BMW_OFF_PF_LIMIT);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      window_low_bound_ff <= BMW_BOUND_RST; // R08
    end else if (wr_mb) begin
      window_low_bound_ff <= bmw_merge(window_low_bound_ff, cfg_req.wdata, cfg_req.be); // R01
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      window_high_bound_ff <= BMW_BOUND_RST; // R08
    end else if (wr_ml) begin
      window_high_bound_ff <= bmw_merge(window_high_bound_ff, cfg_req.wdata, cfg_req.be); // R02
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prefetch_low_bound_ff <= BMW_BOUND_RST; // R08
    end else if (wr_pb) begin
      prefetch_low_bound_ff <= bmw_merge(prefetch_low_bound_ff, cfg_req.wdata, cfg_req.be); // R04
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prefetch_high_bound_ff <= BMW_BOUND_RST; // R08
    end else if (wr_pl) begin
      prefetch_high_bound_ff <= bmw_merge(prefetch_high_bound_ff, cfg_req.wdata, cfg_req.be); // R05
    end
  end

  // ==========================================================================
  // Read path
  logic [15:0] nxt_rdata;
  always_comb begin
    nxt_rdata = 16'h0000;
    unique case (cfg_req.addr)
      BMW_OFF_MEM_BASE: begin
        nxt_rdata = {window_low_bound_ff, BMW_RSVD_LOW}; // R03
      end
      BMW_OFF_MEM_LIMIT: begin
        nxt_rdata = {window_high_bound_ff, BMW_RSVD_LOW}; // R03
      end
      BMW_OFF_PF_BASE: begin
        nxt_rdata = {prefetch_low_bound_ff, BMW_WIDE_ADDRESS_FLAG}; // R06
      end
      BMW_OFF_PF_LIMIT: begin
        nxt_rdata = {prefetch_high_bound_ff, BMW_WIDE_ADDRESS_FLAG}; // R06
      end
      default: begin
        nxt_rdata = 16'h0000;
      end
    endcase
  end

  bmw_cfg_rsp_t cfg_rsp_ff;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg_rsp_ff <= '0;
    end else begin
      cfg_rsp_ff.rvalid <= cfg_req.rd;
      cfg_rsp_ff.rdata <= cfg_req.rd ? nxt_rdata : 16'h0000;
    end
  end
  assign cfg_rsp = cfg_rsp_ff;

  // ==========================================================================
  // Window compare
  logic [63:0] pf_lo;
  logic [63:0] pf_hi;
  logic [31:0] mem_lo;
  logic [31:0] mem_hi;
  assign mem_lo = {window_low_bound_ff, BMW_LOW_ZERO}; // R01
  assign mem_hi = {window_high_bound_ff, BMW_LOW_ONES}; // R02
  assign pf_lo = {pf_base_upper, prefetch_low_bound_ff, BMW_LOW_ZERO}; // R04
  assign pf_hi = {pf_limit_upper, prefetch_high_bound_ff, BMW_LOW_ONES}; // R05

  logic nxt_mem_hit;
  logic nxt_pf_hit;
  // Memory window decodes 32-bit addresses only
  assign nxt_mem_hit = txn_valid && (txn_addr[63:32] == 32'h00000000) &&
                       (txn_addr[31:0] >= mem_lo) && (txn_addr[31:0] <= mem_hi); // R09
  assign nxt_pf_hit = txn_valid && (txn_addr >= pf_lo) && (txn_addr <= pf_hi); // R09

  bmw_hit_t hit_ff;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hit_ff <= '0;
    end else begin
      hit_ff.mem_hit <= nxt_mem_hit; // R07
      hit_ff.pf_hit <= nxt_pf_hit; // R07
    end
  end
  assign hit = hit_ff;

  // ==========================================================================
  // Checks
  // Request steps shared by the properties below
  sequence mem_base_rd_s;
    cfg_req.rd && (cfg_req.addr == BMW_OFF_MEM_BASE);
  endsequence
  sequence mem_lim_rd_s;
    cfg_req.rd && (cfg_req.addr == BMW_OFF_MEM_LIMIT);
  endsequence
  sequence pf_base_rd_s;
    cfg_req.rd && (cfg_req.addr == BMW_OFF_PF_BASE);
  endsequence
  sequence pf_lim_rd_s;
    cfg_req.rd && (cfg_req.addr == BMW_OFF_PF_LIMIT);
  endsequence
  sequence low_txn_s;
    txn_valid && (txn_addr[63:32] == 32'h00000000);
  endsequence

  mem_low_zero_a: assert property (@(posedge clk) disable iff (reset) // R03
    mem_base_rd_s |=> cfg_rsp.rdata[3:0] == 4'h0)
    else $error("memory base low nibble not zero");
  mem_lim_zero_a: assert property (@(posedge clk) disable iff (reset) // R03
    mem_lim_rd_s |=> cfg_rsp.rdata[3:0] == 4'h0)
    else $error("memory limit low nibble not zero");
  pf_flag_read_a: assert property (@(posedge clk) disable iff (reset) // R06
    pf_base_rd_s |=> cfg_rsp.rdata[3:0] == 4'h1)
    else $error("prefetch base wide flag wrong");
  pf_lim_flag_a: assert property (@(posedge clk) disable iff (reset) // R06
    pf_lim_rd_s |=> cfg_rsp.rdata[3:0] == 4'h1)
    else $error("prefetch limit wide flag wrong");
  mem_base_rd_a: assert property (@(posedge clk) disable iff (reset) // R01
    mem_base_rd_s |=> cfg_rsp.rvalid && (cfg_rsp.rdata[15:4] == $past(window_low_bound_ff)))
    else $error("memory base read back wrong");
  mem_lim_rd_a: assert property (@(posedge clk) disable iff (reset) // R02
    mem_lim_rd_s |=> cfg_rsp.rvalid && (cfg_rsp.rdata[15:4] == $past(window_high_bound_ff)))
    else $error("memory limit read back wrong");
  pf_base_rd_a: assert property (@(posedge clk) disable iff (reset) // R04
    pf_base_rd_s |=> cfg_rsp.rvalid && (cfg_rsp.rdata[15:4] == $past(prefetch_low_bound_ff)))
    else $error("prefetch base read back wrong");
  pf_lim_rd_a: assert property (@(posedge clk) disable iff (reset) // R05
    pf_lim_rd_s |=> cfg_rsp.rvalid && (cfg_rsp.rdata[15:4] == $past(prefetch_high_bound_ff)))
    else $error("prefetch limit read back wrong");

  mem_base_wr_a: assert property (@(posedge clk) disable iff (reset) // R01
    wr_mb && (cfg_req.be == 2'h3) |=> window_low_bound_ff == $past(cfg_req.wdata[15:4]))
    else $error("memory base write lost");
  mem_lim_wr_a: assert property (@(posedge clk) disable iff (reset) // R02
    wr_ml && (cfg_req.be == 2'h3) |=> window_high_bound_ff == $past(cfg_req.wdata[15:4]))
    else $error("memory limit write lost");
  pf_base_wr_a: assert property (@(posedge clk) disable iff (reset) // R04
    wr_pb && (cfg_req.be == 2'h3) |=> prefetch_low_bound_ff == $past(cfg_req.wdata[15:4]))
    else $error("prefetch base write lost");
  pf_lim_wr_a: assert property (@(posedge clk) disable iff (reset) // R05
    wr_pl && (cfg_req.be == 2'h3) |=> prefetch_high_bound_ff == $past(cfg_req.wdata[15:4]))
    else $error("prefetch limit write lost");
  // A single lane must leave the other lane's bits untouched
  mem_base_lane_a: assert property (@(posedge clk) disable iff (reset) // R01
    wr_mb && (cfg_req.be == 2'h1) |=>
    window_low_bound_ff ==
    {$past(window_low_bound_ff[11:4]), $past(cfg_req.wdata[7:4])})
    else $error("memory base low lane write wrong");
  mem_base_high_a: assert property (@(posedge clk) disable iff (reset) // R01
    wr_mb && (cfg_req.be == 2'h2) |=>
    window_low_bound_ff ==
    {$past(cfg_req.wdata[15:8]), $past(window_low_bound_ff[3:0])})
    else $error("memory base high lane write wrong");
  mem_lim_lane_a: assert property (@(posedge clk) disable iff (reset) // R02
    wr_ml && (cfg_req.be == 2'h1) |=>
    window_high_bound_ff ==
    {$past(window_high_bound_ff[11:4]), $past(cfg_req.wdata[7:4])})
    else $error("memory limit low lane write wrong");
  mem_lim_high_a: assert property (@(posedge clk) disable iff (reset) // R02
    wr_ml && (cfg_req.be == 2'h2) |=>
    window_high_bound_ff ==
    {$past(cfg_req.wdata[15:8]), $past(window_high_bound_ff[3:0])})
    else $error("memory limit high lane write wrong");
  pf_base_lane_a: assert property (@(posedge clk) disable iff (reset) // R04
    wr_pb && (cfg_req.be == 2'h1) |=>
    prefetch_low_bound_ff ==
    {$past(prefetch_low_bound_ff[11:4]), $past(cfg_req.wdata[7:4])})
    else $error("prefetch base low lane write wrong");
  pf_base_high_a: assert property (@(posedge clk) disable iff (reset) // R04
    wr_pb && (cfg_req.be == 2'h2) |=>
    prefetch_low_bound_ff ==
    {$past(cfg_req.wdata[15:8]), $past(prefetch_low_bound_ff[3:0])})
    else $error("prefetch base high lane write wrong");
  pf_lim_lane_a: assert property (@(posedge clk) disable iff (reset) // R05
    wr_pl && (cfg_req.be == 2'h1) |=>
    prefetch_high_bound_ff ==
    {$past(prefetch_high_bound_ff[11:4]), $past(cfg_req.wdata[7:4])})
    else $error("prefetch limit low lane write wrong");
  pf_lim_high_a: assert property (@(posedge clk) disable iff (reset) // R05
    wr_pl && (cfg_req.be == 2'h2) |=>
    prefetch_high_bound_ff ==
    {$past(cfg_req.wdata[15:8]), $past(prefetch_high_bound_ff[3:0])})
    else $error("prefetch limit high lane write wrong");
  bound_hold_a: assert property (@(posedge clk) disable iff (reset) // R01
    !cfg_req.wr || (cfg_req.addr[7:3] != 5'h04) || cfg_req.addr[0] |=>
    $stable(window_low_bound_ff) && $stable(window_high_bound_ff) &&
    $stable(prefetch_low_bound_ff) && $stable(prefetch_high_bound_ff))
    else $error("bound changed without a write to it");

  empty_window_a: assert property (@(posedge clk) disable iff (reset) // R09
    (window_low_bound_ff > window_high_bound_ff) && !wr_mb && !wr_ml |=> !hit.mem_hit)
    else $error("inverted memory window hit");
  mem_hit_a: assert property (@(posedge clk) disable iff (reset) // R07
    low_txn_s ##0 ((txn_addr[31:20] == window_low_bound_ff) &&
    (window_low_bound_ff <= window_high_bound_ff)) |=> hit.mem_hit)
    else $error("memory window missed its base");
  mem_top_a: assert property (@(posedge clk) disable iff (reset) // R09
    low_txn_s ##0 ((txn_addr[31:20] == window_high_bound_ff) &&
    (txn_addr[19:0] == 20'hFFFFF) &&
    (window_low_bound_ff <= window_high_bound_ff)) |=> hit.mem_hit)
    else $error("memory window missed its top");
  no_txn_a: assert property (@(posedge clk) disable iff (reset) // R07
    !txn_valid |=> !hit.mem_hit && !hit.pf_hit)
    else $error("hit without transaction");
  mem_below_a: assert property (@(posedge clk) disable iff (reset) // R01
    txn_valid && (txn_addr[31:20] < window_low_bound_ff) |=> !hit.mem_hit)
    else $error("memory window hit below its base");
  mem_above_a: assert property (@(posedge clk) disable iff (reset) // R02
    txn_valid && (txn_addr[31:20] > window_high_bound_ff) |=> !hit.mem_hit)
    else $error("memory window hit above its limit");
  // The memory window only decodes addresses below 4 GB
  mem_upper_a: assert property (@(posedge clk) disable iff (reset) // R07
    txn_valid && (txn_addr[63:32] != 32'h00000000) |=> !hit.mem_hit)
    else $error("memory window hit a wide address");
  pf_hit_a: assert property (@(posedge clk) disable iff (reset) // R09
    txn_valid && (txn_addr[63:32] == pf_base_upper) &&
    (txn_addr[31:20] == prefetch_low_bound_ff) &&
    ({pf_base_upper, prefetch_low_bound_ff} <= {pf_limit_upper, prefetch_high_bound_ff}) |=>
    hit.pf_hit)
    else $error("prefetch window missed its base");
  pf_top_a: assert property (@(posedge clk) disable iff (reset) // R09
    txn_valid && (txn_addr[63:32] == pf_limit_upper) &&
    (txn_addr[31:20] == prefetch_high_bound_ff) && (txn_addr[19:0] == 20'hFFFFF) &&
    ({pf_base_upper, prefetch_low_bound_ff} <= {pf_limit_upper, prefetch_high_bound_ff}) |=>
    hit.pf_hit)
    else $error("prefetch window missed its top");
  pf_below_a: assert property (@(posedge clk) disable iff (reset) // R04
    txn_valid && (txn_addr[63:20] < {pf_base_upper, prefetch_low_bound_ff}) |=> !hit.pf_hit)
    else $error("prefetch window hit below its base");
  pf_above_a: assert property (@(posedge clk) disable iff (reset) // R05
    txn_valid && (txn_addr[63:20] > {pf_limit_upper, prefetch_high_bound_ff}) |=> !hit.pf_hit)
    else $error("prefetch window hit above its limit");
  pf_empty_a: assert property (@(posedge clk) disable iff (reset) // R09
    {pf_base_upper, prefetch_low_bound_ff} > {pf_limit_upper, prefetch_high_bound_ff} |=>
    !hit.pf_hit)
    else $error("inverted prefetch window hit");

  reset_value_a: assert property (@(posedge clk) // R08
    $fell(reset) |-> (window_low_bound_ff == 12'h000) && (window_high_bound_ff == 12'h000) &&
    (prefetch_low_bound_ff == 12'h000) && (prefetch_high_bound_ff == 12'h000) &&
    !cfg_rsp.rvalid && !hit.mem_hit && !hit.pf_hit)
    else $error("state not cleared by reset");

endmodule

`default_nettype wire

// *** bench/bmw_testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
module testbench import bmw_pkg::*; ;
  logic clk = 1'b0;
  logic reset = 1'b1;
  bmw_cfg_req_t req = '0;
  bmw_cfg_rsp_t rsp;
  logic [31:0] pbu = 32'h0;
  logic [31:0] plu = 32'h0;
  logic tv = 1'b0;
  logic [63:0] ta = 64'h0;
  bmw_hit_t hit;
  logic [11:0] bnd [4];
  logic [15:0] rq [$];
  logic [1:0] hq [$];
  logic tv_seen = 1'b0;
  int err_count = 0;
  int checked = 0;
  int seed = 32'h7484bc9a;
  logic [63:0] pts [10] = '{64'h12300000, 64'h122FFFFF, 64'h456FFFFF, 64'h45700000,
    64'h1_12300000, 64'h1_80000000, 64'h1_7FFFFFFF, 64'h2_900FFFFF, 64'h2_90100000, 64'h0};

  bmw_regs dut (.clk(clk), .reset(reset), .cfg_req(req), .cfg_rsp(rsp), .pf_base_upper(pbu),
    .pf_limit_upper(plu), .txn_valid(tv), .txn_addr(ta), .hit(hit));

  always #5 clk = ~clk;

  // ==========================================================================
  // Reference model
  function automatic logic [15:0] rexp(input logic [7:0] a);
    if (a[7:3] != 5'h04 || a[0])
      return 16'h0000;
    return {bnd[a[2:1]], (a[2] ? 4'h1 : 4'h0)};
  endfunction

  function automatic logic [1:0] hexp(input logic [63:0] a);
    logic m;
    logic p;
    m = a[63:32] == 32'h0 && a[31:0] >= {bnd[0], 20'h0} && a[31:0] <= {bnd[1], 20'hFFFFF};
    p = a >= {pbu, bnd[2], 20'h0} && a <= {plu, bnd[3], 20'hFFFFF};
    return {m, p};
  endfunction

  // ==========================================================================
  // Drivers and checking
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("Counts: %0d checked, %0d errors", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] be);
    @(posedge clk) #1;
    req = '{1'b1, 1'b0, a, d, be};
    if (a[7:3] == 5'h04 && !a[0] && be[0])
      bnd[a[2:1]][3:0] = d[7:4];
    if (a[7:3] == 5'h04 && !a[0] && be[1])
      bnd[a[2:1]][11:4] = d[15:8];
    @(posedge clk) #1;
    req.wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk) #1;
    req = '{1'b0, 1'b1, a, 16'h0, 2'h0};
    rq.push_back(rexp(a));
    @(posedge clk) #1;
    req.rd = 1'b0;
  endtask

  task automatic tx(input logic [63:0] a);
    @(posedge clk) #1;
    tv = 1'b1;
    ta = a;
    hq.push_back(hexp(a));
    @(posedge clk) #1;
    tv = 1'b0;
  endtask

  task automatic settle(input string name);
    for (int i = 0; i < 8 && rq.size() + hq.size() > 0; i++)
      @(negedge clk);
    if (rq.size() + hq.size() > 0) begin
      err_count++;
      $display("Error at %0t: answers missing", $time);
      give_verdict();
    end else begin
      $display("Test %s done", name);
    end
  endtask

  always @(negedge clk) begin
    if (rsp.rvalid === 1'b1 && rq.size() == 0)
      check(16'h1, 16'h0);
    else if (rsp.rvalid === 1'b1)
      check(rsp.rdata, rq.pop_front());
    if (tv_seen)
      check({14'h0, hit}, {14'h0, hq.pop_front()});
    tv_seen = tv;
  end

  // ==========================================================================
  // Main sequence
  initial begin
    bnd = '{12'h0, 12'h0, 12'h0, 12'h0};
    repeat (20) @(posedge clk);
    #1 reset = 1'b0;
    for (int i = 0; i < 10; i++)
      rd(8'h1E + 8'(i));
    settle("reset_values");
    for (int i = 0; i < 24; i++) begin
      wr(8'h20 + 8'($random(seed) & 7), 16'($random(seed)), 2'($random(seed)));
      rd(8'h20 + 8'($random(seed) & 7));
    end
    wr(8'h28, 16'hFFFF, 2'h3);
    for (int i = 0; i < 9; i++)
      rd(8'h20 + 8'(i));
    settle("register_access");
    wr(8'h20, 16'h123F, 2'h3);
    wr(8'h22, 16'h456F, 2'h3);
    wr(8'h24, 16'h800F, 2'h3);
    wr(8'h26, 16'h900F, 2'h3);
    pbu = 32'h1;
    plu = 32'h2;
    foreach (pts[i])
      tx(pts[i]);
    for (int i = 0; i < 20; i++)
      tx({31'h0, 1'($random(seed)), 32'($random(seed))});
    wr(8'h22, 16'h0000, 2'h3);
    tx(64'h12300000);
    tx(64'h000FFFFF);
    settle("window_compare");
    @(posedge clk) #1;
    reset = 1'b1;
    repeat (2) @(posedge clk);
    #1 reset = 1'b0;
    bnd = '{12'h0, 12'h0, 12'h0, 12'h0};
    for (int i = 0; i < 8; i++)
      rd(8'h20 + 8'(i));
    settle("second_reset");
    give_verdict();
  end
endmodule
`default_nettype wire
